// ### logic/parity_error_logger.sv
// Memory parity error logger: address capture, sticky status, bus error replies.
// Assumes the memory controller reports each checked read on SYS_CLK_I as one valid cycle.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module parity_error_logger (
  input  wire logic                       SYS_CLK_I,
  input  wire logic                       SRST_I,
  input  wire parity_log_pkg::mem_check_t CHECK_I,
  input  wire parity_log_pkg::reg_req_t   REG_I,
  output logic [31:0]                     RDATA_O,
  output logic                            CPU_BUS_ERR_O,
  output logic                            VME_BUS_ERR_O,
  output logic                            IRQ_O
);
  import parity_log_pkg::*;

  logic        rd_status;
  logic        rd_addr;
  logic        rd_istat;
  logic        rd_imask;
  logic [3:0]  clr_acc;
  logic        wr_istat;
  logic        wr_imask;
  logic        wr_addr_clr;
  logic        rd_unmapped;

  logic [31:0] err_addr_r;
  logic        addr_held_r;
  logic [3:0]  byte_flags_r;
  logic [3:0]  acc_flags_r;
  logic [3:0]  int_stat_r;
  logic [3:0]  int_mask_r;
  logic [31:0] rdata_nxt;
  logic        err_now;
  logic [3:0]  acc_set;

  parity_reg_port u_port (
    .clk_i        (SYS_CLK_I),
    .rst_i        (SRST_I),
    .req_i        (REG_I),
    .rd_status_o  (rd_status),
    .rd_addr_o    (rd_addr),
    .rd_istat_o   (rd_istat),
    .rd_imask_o   (rd_imask),
    .clr_acc_o    (clr_acc),
    .wr_istat_o   (wr_istat),
    .wr_imask_o   (wr_imask),
    .wr_addr_clr_o(wr_addr_clr),
    .rd_unmapped_o(rd_unmapped)
  );

  always_comb begin
    err_now = CHECK_I.valid && (CHECK_I.byte_err != 4'h0);
    acc_set = err_now ? CHECK_I.master : 4'h0;
  end

  // Address capture; held until software writes the re-arm register
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      err_addr_r  <= ADDR_RESET;
      addr_held_r <= 1'b0;
    end else if (err_now && !addr_held_r) begin
      addr_held_r <= 1'b1;
      if (CHECK_I.master == MST_DMA) begin
        err_addr_r <= {CHECK_I.dev, CHECK_I.addr[DEV_NIBBLE_LSB-1:0]};
      end else begin
        err_addr_r <= CHECK_I.addr;
      end
    end else if (wr_addr_clr) begin
      addr_held_r <= 1'b0;
    end
  end

  // Byte flags: latest error wins, cleared with any access flag clear
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      byte_flags_r <= BYTE_RESET;
    end else if (err_now) begin
      byte_flags_r <= CHECK_I.byte_err;
    end else if (clr_acc != 4'h0) begin
      byte_flags_r <= BYTE_RESET;
    end
  end

  // Sticky access-type flags, set beats clear
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      acc_flags_r <= ACC_RESET;
    end else begin
      acc_flags_r <= (acc_flags_r & ~clr_acc) | acc_set;
    end
  end

  // Bus error replies in the cycle after the failing read; DMA gets none
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      CPU_BUS_ERR_O <= 1'b0;
      VME_BUS_ERR_O <= 1'b0;
    end else begin
      CPU_BUS_ERR_O <= err_now && (CHECK_I.master == MST_CPU);
      VME_BUS_ERR_O <= err_now && (CHECK_I.master == MST_VME);
    end
  end

  // Interrupt status: one sticky bit per access type, write one to clear
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      int_stat_r <= 4'h0;
    end else if (wr_istat) begin
      int_stat_r <= (int_stat_r & ~REG_I.wdata[3:0]) | acc_set;
    end else begin
      int_stat_r <= int_stat_r | acc_set;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      int_mask_r <= INT_MASK_RESET;
    end else if (wr_imask) begin
      int_mask_r <= REG_I.wdata[3:0];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(int_stat_r & int_mask_r);
    end
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    if (rd_status) begin
      rdata_nxt[BYTE_FLAG_LSB+3:BYTE_FLAG_LSB] = byte_flags_r;
      rdata_nxt[ACC_FLAG_LSB+3:ACC_FLAG_LSB]   = acc_flags_r;
    end else if (rd_addr) begin
      rdata_nxt = err_addr_r;
    end else if (rd_istat) begin
      rdata_nxt[3:0] = int_stat_r;
    end else if (rd_imask) begin
      rdata_nxt[3:0] = int_mask_r;
    end else if (rd_unmapped) begin
      rdata_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      RDATA_O <= 32'h00000000;
    end else begin
      RDATA_O <= rdata_nxt;
    end
  end
endmodule // parity_error_logger

// ### logic/parity_log_pkg.sv
// Constants, register map and carrier types for the memory parity error logger.
// Assumes a single 20 MHz system clock and a simple strobe register port.
package parity_log_pkg;

  localparam int          ADDR_W           = 32;
  localparam int          DATA_W           = 32;
  // Register map (byte addresses)
  localparam logic [31:0] ERR_ADDR_OFS     = 32'h1fa40000;
  localparam logic [31:0] PAR_STATUS_OFS   = 32'h1faa0005;
  localparam logic [31:0] CLR_STROBE_BASE  = 32'h1faa0000;
  localparam logic [31:0] CLR_STROBE_MASK  = 32'hfffffff0;
  localparam logic [31:0] INT_STATUS_OFS   = 32'h1faa0100;
  localparam logic [31:0] INT_MASK_OFS     = 32'h1faa0104;
  localparam logic [31:0] ADDR_CLEAR_OFS   = 32'h1faa0108;
  // Status and error-address field positions
  localparam int          BYTE_FLAG_LSB    = 20;
  localparam int          ACC_FLAG_LSB     = 16;
  localparam int          DEV_NIBBLE_LSB   = 28;
  // Access-type flag indices, equal to the clear-strobe nibble
  localparam int          ACC_GRAPHICS_DMA_ACCESS_FLAG         = 0;
  localparam int          ACC_DMA          = 1;
  localparam int          ACC_CPU          = 2;
  localparam int          ACC_VME          = 3;
  localparam logic [3:0]  ACC_RESET        = 4'h0;
  localparam logic [3:0]  BYTE_RESET       = 4'h0;
  localparam logic [3:0]  INT_MASK_RESET   = 4'h0;
  localparam logic [31:0] ADDR_RESET       = 32'h00000000;

  typedef enum logic [3:0] {
    MST_GRAPHICS_DMA_ACCESS_FLAG = 4'b0001,
    MST_DMA  = 4'b0010,
    MST_CPU  = 4'b0100,
    MST_VME  = 4'b1000
  } master_t;

  // One checked memory read, as reported by the memory controller
  typedef struct packed {
    logic                 valid;
    master_t              master;
    logic [ADDR_W-1:0]    addr;
    logic [3:0]           dev;       // One-hot multiplexer device: audio,printer,ethernet,scsi
    logic [3:0]           byte_err;  // Bit 3 is byte 0 in the status layout
  } mem_check_t;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
  } reg_req_t;

endpackage : parity_log_pkg

// ### logic/parity_reg_port.sv
// Register port decode for the parity error logger.
// Assumes one-cycle read and write strobes on the system clock, never together.
`timescale 1ns/100ps
module parity_reg_port (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire parity_log_pkg::reg_req_t req_i,
  output logic                        rd_status_o,
  output logic                        rd_addr_o,
  output logic                        rd_istat_o,
  output logic                        rd_imask_o,
  output logic [3:0]                  clr_acc_o,
  output logic                        wr_istat_o,
  output logic                        wr_imask_o,
  output logic                        wr_addr_clr_o,
  output logic                        rd_unmapped_o
);
  import parity_log_pkg::*;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction

  logic clr_hit;

  always_comb begin
    clr_hit       = ((req_i.addr & CLR_STROBE_MASK) == CLR_STROBE_BASE) && (req_i.addr[3:2] == 2'b00);
    rd_status_o   = req_i.rd && hit(req_i.addr, PAR_STATUS_OFS);
    rd_addr_o     = req_i.rd && hit(req_i.addr, ERR_ADDR_OFS);
    rd_istat_o    = req_i.rd && hit(req_i.addr, INT_STATUS_OFS);
    rd_imask_o    = req_i.rd && hit(req_i.addr, INT_MASK_OFS);
    clr_acc_o     = 4'h0;
    if (req_i.rd && clr_hit) begin
      clr_acc_o[req_i.addr[1:0]] = 1'b1;
    end
    wr_istat_o    = req_i.wr && hit(req_i.addr, INT_STATUS_OFS);
    wr_imask_o    = req_i.wr && hit(req_i.addr, INT_MASK_OFS);
    wr_addr_clr_o = req_i.wr && hit(req_i.addr, ADDR_CLEAR_OFS);
    rd_unmapped_o = req_i.rd && !(rd_status_o || rd_addr_o || rd_istat_o || rd_imask_o || clr_hit);
  end

  // Unused clock and reset kept so the port can later register its decode
  logic unused_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unused_r <= 1'b0;
    end else begin
      unused_r <= 1'b0;
    end
  end
endmodule // parity_reg_port

// ### tb/mem_check_model.sv
// Memory-side model: reports one checked read per call.
// Assumes the logger samples its input on the rising edge.
`timescale 1ns/100ps
module mem_check_model (
  input  wire logic                  clk_i,
  input  wire logic                  vme_berr_i,
  output parity_log_pkg::mem_check_t check_o
);
  import parity_log_pkg::*;
  int aborts = 0;
  initial check_o = '0;
  task automatic chk(input master_t m, input logic [31:0] a, input logic [3:0] dv, input logic [3:0] be);
    mem_check_t idle;
    idle = '{1'b0, m, ~a, ~dv, ~be};
    @(posedge clk_i);
    check_o <= '{1'b1, m, a, dv, be};
    @(posedge clk_i);
    // Stale address, device and byte fields are inverted so a late sample cannot pass by luck
    check_o <= idle;
  endtask
  // The VME master drops its cycle on a bus error; the count stands in for recovery
  always @(posedge clk_i) if (vme_berr_i) aborts <= aborts + 1;
endmodule // mem_check_model

// ### tb/parity_error_logger_asserts.sv
// Port-level checks for the parity error logger.
// Assumes rd and wr strobes are never high together.
`timescale 1ns/100ps
module parity_error_logger_asserts (
  input wire logic                       SYS_CLK_I,
  input wire logic                       SRST_I,
  input wire parity_log_pkg::mem_check_t CHECK_I,
  input wire parity_log_pkg::reg_req_t   REG_I,
  input wire logic [31:0]                RDATA_O,
  input wire logic                       CPU_BUS_ERR_O,
  input wire logic                       VME_BUS_ERR_O,
  input wire logic                       IRQ_O
);
  import parity_log_pkg::*;
  logic e_any, e_cpu, e_vme, rd_st, clr;
  assign e_any = CHECK_I.valid && (CHECK_I.byte_err != 4'h0);
  assign e_cpu = e_any && (CHECK_I.master == MST_CPU);
  assign e_vme = e_any && (CHECK_I.master == MST_VME);
  assign rd_st = REG_I.rd && (REG_I.addr == PAR_STATUS_OFS);
  assign clr   = REG_I.rd && (REG_I.addr[31:2] == CLR_STROBE_BASE[31:2]);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  a_cpu_berr: assert property (e_cpu |=> CPU_BUS_ERR_O) else $error("no cpu berr");
  a_cpu_cause: assert property (CPU_BUS_ERR_O |-> $past(e_cpu)) else $error("stray cpu berr");
  a_vme_berr: assert property (e_vme |=> VME_BUS_ERR_O) else $error("no vme berr");
  a_vme_cause: assert property (VME_BUS_ERR_O |-> $past(e_vme)) else $error("stray vme berr");
  a_clr_zero: assert property (clr |=> RDATA_O == 32'h0) else $error("clear read data");
  a_stat_bytes: assert property (e_any ##1 !CHECK_I.valid && !clr ##1 rd_st |=> RDATA_O[23:20] == $past(CHECK_I.byte_err, 3))
    else $error("byte flags wrong");
  a_clr_bytes: assert property (clr && !CHECK_I.valid ##1 !CHECK_I.valid ##1 rd_st
    |=> RDATA_O[23:20] == 4'h0 && !RDATA_O[16 + $past(REG_I.addr[1:0], 3)]) else $error("clear failed");
  a_set_wins: assert property (e_vme && clr && REG_I.addr[1:0] == 2'h3 ##1 !REG_I.rd ##1 rd_st |=> RDATA_O[19])
    else $error("clear beat new error");
  c_dma: cover property (e_any && CHECK_I.master == MST_DMA);
  c_clr: cover property (clr);
  c_irq: cover property (IRQ_O);
endmodule // parity_error_logger_asserts

bind parity_error_logger parity_error_logger_asserts u_chk (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .CHECK_I(CHECK_I),
  .REG_I(REG_I), .RDATA_O(RDATA_O), .CPU_BUS_ERR_O(CPU_BUS_ERR_O), .VME_BUS_ERR_O(VME_BUS_ERR_O), .IRQ_O(IRQ_O));

// ### tb/parity_error_logger_tb.sv
// Self-checking bench for the parity error logger.
// Registers are driven directly; the memory-side model reports checked reads.
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module parity_error_logger_tb;
  import parity_log_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  reg_req_t    req = '0;
  mem_check_t  chk_s;
  logic [31:0] rdata;
  logic        cpu_be, vme_be, irq;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  initial forever #25 clk = ~clk;
  parity_error_logger DUT (.SYS_CLK_I(clk), .SRST_I(rst), .CHECK_I(chk_s), .REG_I(req), .RDATA_O(rdata),
    .CPU_BUS_ERR_O(cpu_be), .VME_BUS_ERR_O(vme_be), .IRQ_O(irq));
  mem_check_model mdl (.clk_i(clk), .vme_berr_i(vme_be), .check_o(chk_s));
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] w);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, w};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_cpu();
    mdl.chk(MST_CPU, 32'h00000104, 4'h0, 4'h1);
    #1 `CHK(cpu_be, 1'b1)
    mdl.chk(MST_GRAPHICS_DMA_ACCESS_FLAG, 32'h00000208, 4'h0, 4'h8);
    #1 `CHK(cpu_be, 1'b0)
    rd(ERR_ADDR_OFS, 32'h00000104);
    rd(PAR_STATUS_OFS, 32'h00850000);
    rd(CLR_STROBE_BASE | 32'h2, 32'h0);
    rd(PAR_STATUS_OFS, 32'h00010000);
    rd(CLR_STROBE_BASE, 32'h0);
    $display("t_cpu done");
  endtask
  task automatic t_dma();
    wr(ADDR_CLEAR_OFS, 32'h1);
    mdl.chk(MST_DMA, 32'h00001230, 4'h4, 4'h2);
    #1 `CHK({cpu_be, vme_be}, 2'b00)
    rd(ERR_ADDR_OFS, 32'h40001230);
    rd(PAR_STATUS_OFS, 32'h00220000);
    rd(CLR_STROBE_BASE | 32'h1, 32'h0);
    rd(PAR_STATUS_OFS, 32'h0);
    $display("t_dma done");
  endtask
  task automatic t_vme();
    mdl.chk(MST_VME, 32'h00000300, 4'h0, 4'hf);
    #1 `CHK(vme_be, 1'b1)
    rd(PAR_STATUS_OFS, 32'h00f80000);
    rd(INT_STATUS_OFS, 32'h0000000f);
    rd(32'h1faa0009, 32'h0);
    wr(INT_MASK_OFS, 32'hf);
    @(posedge clk) #1 `CHK(irq, 1'b1)
    wr(INT_MASK_OFS, 32'h0);
    @(posedge clk) #1 `CHK(irq, 1'b0)
    wr(INT_MASK_OFS, 32'hf);
    wr(INT_STATUS_OFS, 32'hf);
    @(posedge clk) #1 `CHK(irq, 1'b0)
    rd(CLR_STROBE_BASE | 32'h3, 32'h0);
    `CHK(mdl.aborts, 1)
    $display("t_vme done");
  endtask
  task automatic t_win();
    fork
      mdl.chk(MST_VME, 32'h00000400, 4'h0, 4'h4);
      rd(CLR_STROBE_BASE | 32'h3, 32'h0);
    join
    rd(PAR_STATUS_OFS, 32'h00480000);
    $display("t_win done");
  endtask
  // Whole run is about 60 cycles; the ceiling of 3000 leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_cpu();
    t_dma();
    t_vme();
    t_win();
    stop_test();
  end
endmodule // parity_error_logger_tb
